//--- include/bsm_defs.svh
/*
  Constants of the binary signal matrix: bank sizes, source vector layout,
  index widths and reset values.
  Assumes inclusion by bare name from the package, bsm_top and the checker.
*/
`ifndef BSM_DEFS_SVH
`define BSM_DEFS_SVH

// ----------------------------------------------------------------------
// Bank sizes and logical bank index width
// ----------------------------------------------------------------------
`define BSM_NLIN 32
`define BSM_NLOUT 32
`define BSM_NNET 64
`define BSM_LIW 5

// ----------------------------------------------------------------------
// Source vector layout and selector width
// ----------------------------------------------------------------------
`define BSM_SELW 7
`define BSM_SRC_LIN 0
`define BSM_SRC_LOUT 32
`define BSM_SRC_DIN 64

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BSM_RST_BANK 32'h0000_0000
`define BSM_RST_NET 64'h0000_0000_0000_0000

`endif

//--- include/bsm_pkg.sv
/*
  Types shared by the binary signal matrix modules.
  Assumes bsm_defs.svh is on the include path.
*/
`include "bsm_defs.svh"

package bsm_pkg;

  // Which of the four event mask banks a mask write targets
  typedef enum logic [1:0] {
    MSEL_LIN_ON,
    MSEL_LIN_OFF,
    MSEL_LOUT_ON,
    MSEL_LOUT_OFF
  } bsm_msel_e;

  // One routing matrix entry per output relay or LED
  typedef struct packed {
    logic en;
    logic latch;
    logic [`BSM_SELW-1:0] sel;
  } bsm_route_s;

endpackage : bsm_pkg

//--- hdl/bsm_route_mem.sv
/*
  Routing table memory: one entry per output, synchronous write,
  registered read data.
  Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module bsm_route_mem #(
  parameter int DEPTH = 24,
  parameter int WIDTH = 9,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata_q
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rdata;
  } bsm_mem_s;

  bsm_mem_s q;
  bsm_mem_s d;

  // Read first, read sees old contents; entries cleared so no route is live
  always_comb begin
    d = q;
    if (we && (int'(waddr) < DEPTH)) begin
      d.mem[waddr] = wdata;
    end
    d.rdata = (int'(raddr) < DEPTH) ? q.mem[raddr] : '0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata_q = q.rdata;

endmodule : bsm_route_mem

`default_nettype wire

//--- hdl/bsm_evt.sv
/*
  Masked ON/OFF event generator for one bank of status bits.
  Assumes the bank is already registered in the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module bsm_evt #(
  parameter int N = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [N-1:0] vec,
  input wire logic [N-1:0] mask_on,
  input wire logic [N-1:0] mask_off,
  output logic [N-1:0] on_evt_q,
  output logic [N-1:0] off_evt_q
);

  typedef struct packed {
    logic [N-1:0] prev;
    logic [N-1:0] on_evt;
    logic [N-1:0] off_evt;
  } bsm_evt_s;

  bsm_evt_s q;
  bsm_evt_s d;

  // Edge compare against last value; prev starts at 0 so no event at reset
  always_comb begin
    d = q;
    d.prev = vec;
    d.on_evt = vec & ~q.prev & mask_on;
    d.off_evt = ~vec & q.prev & mask_off;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign on_evt_q = q.on_evt;
  assign off_evt_q = q.off_evt;

endmodule : bsm_evt

`default_nettype wire

//--- hdl/bsm_top.sv
/*
  Binary signal matrix: routes digital inputs, logical signals, stage
  status and object status to output relays and LEDs, latched or not,
  and holds the logical input, logical output and network input banks,
  masked ON/OFF events for the two logical banks, panel switches and mimic indicators.
  Assumes one 50 MHz clock, inputs synchronous to it, and configuration
  strobes that are one-cycle pulses from the surrounding controller.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bsm_defs.svh"

module bsm_top #(
  parameter int NDI = 8,
  parameter int NSTG = 8,
  parameter int NOBJ = 8,
  parameter int NREL = 8,
  parameter int NLED = 16,
  parameter int NPCS = 8,
  parameter int LVLW = 2,
  parameter int NIND = 8,
  parameter int OIW = $clog2(NREL + NLED),
  parameter int PIW = $clog2(NPCS),
  parameter int IIW = $clog2(NIND)
) (
  input wire logic clk,
  input wire logic rst_b,
  // Binary sources
  input wire logic [NDI-1:0] din,
  input wire logic [NSTG-1:0] stage_start,
  input wire logic [NSTG-1:0] stage_trip,
  input wire logic [NSTG-1:0] stage_blocked,
  input wire logic [NOBJ-1:0] obj_status,
  input wire logic [`BSM_NLOUT-1:0] logic_result,
  input wire logic [`BSM_NNET-1:0] net_in,
  input wire logic [`BSM_NNET-1:0] net_qual,
  // Routing table writes
  input wire logic route_we,
  input wire logic [OIW-1:0] route_idx,
  input wire logic [`BSM_SELW-1:0] route_src,
  input wire logic route_latch,
  input wire logic route_en,
  // Latch clearing
  input wire logic latch_clear,
  input wire logic back_key,
  input wire logic mimic_active,
  // Logical input requests
  input wire logic mimic_req,
  input wire logic [`BSM_LIW-1:0] mimic_idx,
  input wire logic mimic_val,
  input wire logic remote_req,
  input wire logic [`BSM_LIW-1:0] remote_idx,
  input wire logic remote_val,
  input wire logic lin_mode_we,
  input wire logic [`BSM_LIW-1:0] lin_mode_idx,
  input wire logic lin_mode_pulse,
  // Event masks
  input wire logic mask_we,
  input wire bsm_pkg::bsm_msel_e mask_sel,
  input wire logic [`BSM_LIW-1:0] mask_idx,
  input wire logic mask_val,
  // Panel control switches
  input wire logic pcs_cfg_we,
  input wire logic [PIW-1:0] pcs_cfg_idx,
  input wire logic [LVLW-1:0] pcs_cfg_level,
  input wire logic pcs_req,
  input wire logic [PIW-1:0] pcs_idx,
  input wire logic pcs_val,
  input wire logic [LVLW-1:0] pcs_level,
  // Mimic indicators
  input wire logic ind_cfg_we,
  input wire logic [IIW-1:0] ind_cfg_idx,
  input wire logic [`BSM_SELW-1:0] ind_cfg_src,
  // Outputs
  output logic [NREL-1:0] relay_q,
  output logic [NLED-1:0] led_q,
  output logic [`BSM_NLIN-1:0] lin_q,
  output logic [`BSM_NLOUT-1:0] lout_q,
  output logic [`BSM_NNET-1:0] net_in_q,
  output logic [`BSM_NNET-1:0] net_input_quality_flag_q,
  output logic [`BSM_NLIN-1:0] lin_on_evt_q,
  output logic [`BSM_NLIN-1:0] lin_off_evt_q,
  output logic [`BSM_NLOUT-1:0] lout_on_evt_q,
  output logic [`BSM_NLOUT-1:0] lout_off_evt_q,
  output logic [NPCS-1:0] panel_control_switch_q,
  output logic pcs_denied_q,
  output logic [NIND-1:0] ind_on_q
);

  // ----------------------------------------------------------------------
  // Sizes and state
  // ----------------------------------------------------------------------
  localparam int NOUT = NREL + NLED;
  localparam int NSRC = `BSM_SRC_DIN + NDI + 3 * NSTG + NOBJ;
  localparam int RW = $bits(bsm_pkg::bsm_route_s);

  typedef struct packed {
    logic [`BSM_NLIN-1:0] lin;
    logic [`BSM_NLIN-1:0] lin_pulse;
    logic [`BSM_NLOUT-1:0] lout;
    logic [`BSM_NNET-1:0] net;
    logic [`BSM_NNET-1:0] qual;
    logic [`BSM_NLIN-1:0] lin_mon;
    logic [`BSM_NLIN-1:0] lin_moff;
    logic [`BSM_NLOUT-1:0] lout_mon;
    logic [`BSM_NLOUT-1:0] lout_moff;
    logic [NOUT-1:0] lat;
    logic [NOUT-1:0] pend;
    logic [NOUT-1:0] outs;
    logic [OIW-1:0] scan;
    logic [OIW-1:0] eval_idx;
    logic eval_v;
    logic [NPCS-1:0] panel_control_switch;
    logic [NPCS*LVLW-1:0] pcs_lvl;
    logic denied;
    logic [NIND*`BSM_SELW-1:0] ind_sel;
    logic [NIND-1:0] ind_on;
  } bsm_state_s;

  bsm_state_s q;
  bsm_state_s d;
  logic [NSRC-1:0] src;
  logic [RW-1:0] rd_raw;
  bsm_pkg::bsm_route_s ent;
  bsm_pkg::bsm_route_s wr_ent;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Out-of-range selectors read as an idle source rather than X
  function automatic logic src_pick(input logic [NSRC-1:0] v,
                                    input logic [`BSM_SELW-1:0] sel);
    src_pick = (int'(sel) < NSRC) ? v[sel] : 1'b0;
  endfunction : src_pick

  // Hold mode takes the written value, pulse mode only reacts to a 1
  function automatic logic [`BSM_NLIN-1:0] lin_apply(
      input logic [`BSM_NLIN-1:0] cur,
      input logic [`BSM_NLIN-1:0] pulse,
      input logic [`BSM_LIW-1:0] idx,
      input logic val);
    lin_apply = cur;
    if (!pulse[idx]) begin
      lin_apply[idx] = val;
    end else if (val) begin
      lin_apply[idx] = 1'b1;
    end
  endfunction : lin_apply

  // ----------------------------------------------------------------------
  // Source vector
  // ----------------------------------------------------------------------

  // Logical banks first so their selector codes are fixed by the header
  assign src = {obj_status, stage_blocked, stage_trip, stage_start, din,
                q.lout, q.lin};

  // ----------------------------------------------------------------------
  // Routing table
  // ----------------------------------------------------------------------

  // Table write image from the configuration strobe
  always_comb begin
    wr_ent.en = route_en;
    wr_ent.latch = route_latch;
    wr_ent.sel = route_src;
  end

  // Entry read one cycle after its index is issued by the scan counter
  bsm_route_mem #(
    .DEPTH(NOUT),
    .WIDTH(RW),
    .AW(OIW)
  ) u_route (
    .clk(clk),
    .rst_b(rst_b),
    .we(route_we),
    .waddr(route_idx),
    .wdata(wr_ent),
    .raddr(q.scan),
    .rdata_q(rd_raw)
  );

  assign ent = bsm_pkg::bsm_route_s'(rd_raw);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic on;
    logic lat_n;
    logic clr;
    on = 1'b0;
    lat_n = 1'b0;
    clr = 1'b0;
    d = q;

    // Banks sampled each cycle; the logic program owns the outputs
    d.lout = logic_result;
    d.net = net_in;
    d.qual = net_qual;

    // Pulse inputs fall back to 0 one cycle after being set
    d.lin = q.lin & ~q.lin_pulse;
    // Remote first so a panel request to the same bit wins
    if (remote_req) begin
      d.lin = lin_apply(d.lin, q.lin_pulse, remote_idx, remote_val);
    end
    if (mimic_req) begin
      d.lin = lin_apply(d.lin, q.lin_pulse, mimic_idx, mimic_val);
    end
    if (lin_mode_we) begin
      d.lin_pulse[lin_mode_idx] = lin_mode_pulse;
    end

    // Event mask writes; banks reset masked off
    if (mask_we) begin
      case (mask_sel)
        bsm_pkg::MSEL_LIN_ON: d.lin_mon[mask_idx] = mask_val;
        bsm_pkg::MSEL_LIN_OFF: d.lin_moff[mask_idx] = mask_val;
        bsm_pkg::MSEL_LOUT_ON: d.lout_mon[mask_idx] = mask_val;
        bsm_pkg::MSEL_LOUT_OFF: d.lout_moff[mask_idx] = mask_val;
        default: d.lin_mon = q.lin_mon;
      endcase
    end

    // Scan walks the table; every output is refreshed once per NOUT cycles
    d.scan = (int'(q.scan) == NOUT - 1) ? '0 : q.scan + 1'b1;
    d.eval_idx = q.scan;
    d.eval_v = 1'b1;

    // Evaluate the entry that came back from the table this cycle
    if (q.eval_v) begin
      on = ent.en & src_pick(src, ent.sel);
      if (!ent.latch) begin
        d.lat[q.eval_idx] = 1'b0;
        d.outs[q.eval_idx] = on;
      end else begin
        lat_n = q.lat[q.eval_idx] | on;
        // A pending clear only releases a latch whose source is gone
        if (q.pend[q.eval_idx] && !on) begin
          lat_n = 1'b0;
        end
        d.lat[q.eval_idx] = lat_n;
        d.outs[q.eval_idx] = on | lat_n;
      end
      d.pend[q.eval_idx] = 1'b0;
    end

    // Clear request is stored per output; a new request beats consumption
    clr = latch_clear | (back_key & mimic_active);
    if (clr) begin
      d.pend = '1;
    end

    // Panel switch access check against the configured level
    d.denied = 1'b0;
    if (pcs_cfg_we) begin
      d.pcs_lvl[pcs_cfg_idx*LVLW +: LVLW] = pcs_cfg_level;
    end
    if (pcs_req) begin
      if (pcs_level >= q.pcs_lvl[pcs_idx*LVLW +: LVLW]) begin
        d.panel_control_switch[pcs_idx] = pcs_val;
      end else begin
        d.denied = 1'b1;
      end
    end

    // Mimic indicators follow their bound source every cycle
    if (ind_cfg_we) begin
      d.ind_sel[ind_cfg_idx*`BSM_SELW +: `BSM_SELW] = ind_cfg_src;
    end
    for (int k = 0; k < NIND; k++) begin
      d.ind_on[k] = src_pick(src, q.ind_sel[k*`BSM_SELW +: `BSM_SELW]);
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Everything starts cleared, masks off and all inputs in hold mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------------

  // Logical input events from the registered bank
  bsm_evt #(
    .N(`BSM_NLIN)
  ) u_lin_evt (
    .clk(clk),
    .rst_b(rst_b),
    .vec(q.lin),
    .mask_on(q.lin_mon),
    .mask_off(q.lin_moff),
    .on_evt_q(lin_on_evt_q),
    .off_evt_q(lin_off_evt_q)
  );

  // Gate activity only shows as an event once it lands on an output bit
  bsm_evt #(
    .N(`BSM_NLOUT)
  ) u_lout_evt (
    .clk(clk),
    .rst_b(rst_b),
    .vec(q.lout),
    .mask_on(q.lout_mon),
    .mask_off(q.lout_moff),
    .on_evt_q(lout_on_evt_q),
    .off_evt_q(lout_off_evt_q)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // All straight from state flops
  assign relay_q = q.outs[NREL-1:0];
  assign led_q = q.outs[NOUT-1:NREL];
  assign lin_q = q.lin;
  assign lout_q = q.lout;
  assign net_in_q = q.net;
  assign net_input_quality_flag_q = q.qual;
  assign panel_control_switch_q = q.panel_control_switch;
  assign pcs_denied_q = q.denied;
  assign ind_on_q = q.ind_on;

endmodule : bsm_top

`default_nettype wire

//--- sim/bsm_checker.sv
/*
  Checker for bsm_top: bank loading, logical input requests, events, switches.
  Assumes bind into bsm_top, whose port names it reuses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bsm_defs.svh"

module bsm_checker #(
  parameter int LVLW = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [`BSM_NLOUT-1:0] logic_result,
  input wire logic [`BSM_NLOUT-1:0] lout_q,
  input wire logic [`BSM_NNET-1:0] net_in,
  input wire logic [`BSM_NNET-1:0] net_in_q,
  input wire logic [`BSM_NNET-1:0] net_qual,
  input wire logic [`BSM_NNET-1:0] net_input_quality_flag_q,
  input wire logic mimic_req,
  input wire logic [`BSM_LIW-1:0] mimic_idx,
  input wire logic mimic_val,
  input wire logic remote_req,
  input wire logic [`BSM_LIW-1:0] remote_idx,
  input wire logic remote_val,
  input wire logic [`BSM_NLIN-1:0] lin_q,
  input wire logic [`BSM_NLIN-1:0] lin_on_evt_q,
  input wire logic [`BSM_NLIN-1:0] lin_off_evt_q,
  input wire logic pcs_req,
  input wire logic [LVLW-1:0] pcs_level,
  input wire logic pcs_denied_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----
  // Sequences: a request and the bank rise it causes
  // ----
  sequence s_mset;
    mimic_req && mimic_val;
  endsequence
  sequence s_rset;
    remote_req && remote_val && !(mimic_req && mimic_idx == remote_idx);
  endsequence

  // First edge after release is skipped: the banks were still held in reset
  property p_lout;
    $past(rst_b) |-> lout_q == $past(logic_result);
  endproperty
  a_lout: assert property (p_lout) else $error("lout bank lag");
  property p_net;
    $past(rst_b) |-> net_in_q == $past(net_in);
  endproperty
  a_net: assert property (p_net) else $error("net bank lag");
  property p_qual;
    $past(rst_b) |-> net_input_quality_flag_q == $past(net_qual);
  endproperty
  a_qual: assert property (p_qual) else $error("quality bank lag");
  // Without a request no logical input may rise
  property p_hold;
    !mimic_req && !remote_req |=> (lin_q & ~$past(lin_q)) == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("lin rose unasked");
  property p_mreq;
    s_mset |=> lin_q[$past(mimic_idx)];
  endproperty
  a_mreq: assert property (p_mreq) else $error("mimic set lost");
  property p_rreq;
    s_rset |=> lin_q[$past(remote_idx)];
  endproperty
  a_rreq: assert property (p_rreq) else $error("remote set lost");
  // An event only follows a real edge of its bit one cycle earlier
  property p_onevt;
    lin_on_evt_q != '0 |-> (lin_on_evt_q & ~($past(lin_q) & ~$past(lin_q, 2))) == '0;
  endproperty
  a_onevt: assert property (p_onevt) else $error("ON event without rise");
  property p_offevt;
    lin_off_evt_q != '0 |-> (lin_off_evt_q & ~(~$past(lin_q) & $past(lin_q, 2))) == '0;
  endproperty
  a_offevt: assert property (p_offevt) else $error("OFF event without fall");
  property p_pcs;
    !pcs_req || pcs_level == '1 |=> !pcs_denied_q;
  endproperty
  a_pcs: assert property (p_pcs) else $error("switch request wrongly denied");
endmodule : bsm_checker

bind bsm_top bsm_checker #(.LVLW(LVLW)) CHK (.*);

`default_nettype wire

//--- sim/bsm_panel.sv
/*
  Mimic panel user model: on press, optionally enters the mimic view and
  taps the back key for one cycle.
  Assumes press is a one-cycle pulse from the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module bsm_panel (
  input wire logic clk,
  input wire logic press,
  input wire logic in_view,
  output logic mimic_active,
  output logic back_key
);
  initial begin
    mimic_active = 1'b0;
    back_key = 1'b0;
  end
  // View is held around the key so the clear sees both; without view it must not clear
  always @(posedge clk) begin
    if (press) begin
      mimic_active <= in_view;
      @(posedge clk);
      back_key <= 1'b1;
      @(posedge clk);
      back_key <= 1'b0;
      mimic_active <= 1'b0;
    end
  end
endmodule : bsm_panel

`default_nettype wire

//--- sim/testbench.sv
/*
  Self-checking bench for bsm_top: pulsed request tasks and scenarios.
  Assumes the design, checker and panel model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk, rst_b, press, in_view, back_key, mimic_active, pcs_denied_q;
  logic [7:0] din, stage_start, stage_trip, stage_blocked, obj_status;
  logic [7:0] relay_q, panel_control_switch_q, ind_on_q;
  logic [15:0] led_q;
  logic [31:0] logic_result, lin_q, lout_q, lin_on_evt_q, lin_off_evt_q;
  logic [31:0] lout_on_evt_q, lout_off_evt_q;
  logic [63:0] net_in, net_qual, net_in_q, net_input_quality_flag_q;
  logic route_we, route_latch, route_en, latch_clear, lin_mode_we, lin_mode_pulse;
  logic mimic_req, mimic_val, remote_req, remote_val, mask_we, mask_val;
  logic pcs_cfg_we, pcs_req, pcs_val, ind_cfg_we;
  logic [4:0] route_idx, mimic_idx, remote_idx, lin_mode_idx, mask_idx;
  logic [6:0] route_src, ind_cfg_src;
  logic [2:0] pcs_cfg_idx, pcs_idx, ind_cfg_idx;
  logic [1:0] pcs_cfg_level, pcs_level;
  bsm_pkg::bsm_msel_e mask_sel;
  int bad_count, checked, cyc;

  bsm_top DUT (.*);
  bsm_panel PNL (.clk(clk), .press(press), .in_view(in_view),
    .mimic_active(mimic_active), .back_key(back_key));

  // ----
  // Clock, timeout and verdict
  // ----
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // ----
  // Access tasks; inputs move 1 ns after the edge
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Config writes end with a spare cycle so strobes never toggle twice at once
  task automatic route(input logic [4:0] i, input logic [6:0] s, input logic l);
    route_idx = i;
    route_src = s;
    route_latch = l;
    route_en = 1'b1;
    route_we = 1'b1;
    tick(1);
    route_we = 1'b0;
    tick(1);
  endtask : route
  task automatic mask(input bsm_pkg::bsm_msel_e s, input logic [4:0] i);
    mask_sel = s;
    mask_idx = i;
    mask_val = 1'b1;
    mask_we = 1'b1;
    tick(1);
    mask_we = 1'b0;
    tick(1);
  endtask : mask
  // Both sources on one bit carry opposite values
  task automatic lreq(input logic m, input logic r, input logic [4:0] i, input logic v);
    mimic_req = m;
    remote_req = r;
    mimic_idx = i;
    remote_idx = i;
    mimic_val = v;
    remote_val = m ? !v : v;
    tick(1);
    mimic_req = 1'b0;
    remote_req = 1'b0;
  endtask : lreq
  task automatic preq(input logic [2:0] i, input logic v, input logic [1:0] lv);
    pcs_idx = i;
    pcs_val = v;
    pcs_level = lv;
    pcs_req = 1'b1;
    tick(1);
    pcs_req = 1'b0;
  endtask : preq
  task automatic tap(input logic v);
    in_view = v;
    press = 1'b1;
    tick(1);
    press = 1'b0;
    tick(30);
  endtask : tap

  // ----
  // Scenarios
  // ----
  initial begin
    {din, stage_start, stage_trip, stage_blocked, obj_status, logic_result} = '0;
    {net_in, net_qual, route_we, route_latch, route_en, latch_clear} = '0;
    {route_idx, route_src, mimic_req, mimic_val, remote_req, remote_val} = '0;
    {mimic_idx, remote_idx, lin_mode_we, lin_mode_pulse, lin_mode_idx} = '0;
    {mask_we, mask_val, mask_idx, pcs_cfg_we, pcs_req, pcs_val, pcs_cfg_idx} = '0;
    {pcs_idx, pcs_cfg_level, pcs_level, ind_cfg_we, ind_cfg_idx, ind_cfg_src} = '0;
    {press, in_view} = '0;
    mask_sel = bsm_pkg::MSEL_LIN_ON;
    rst_b = 1'b0;
    tick(20);
    rst_b = 1'b1;
    tick(1);
    chk("outputs", 64'h0, {lin_q, relay_q, led_q, panel_control_switch_q});
    net_in = 64'hA5A5_0F0F_1234_8001;
    net_qual = 64'h5A5A_F0F0_EDCB_7FFE;
    tick(1);
    chk("net_in_q", net_in, net_in_q);
    chk("quality", net_qual, net_input_quality_flag_q);
    lreq(1'b1, 1'b0, 5'h02, 1'b1);
    chk("lin_q", 64'h4, lin_q);
    tick(1);
    chk("lin_on_evt_q", 64'h0, lin_on_evt_q);
    mask(bsm_pkg::MSEL_LIN_ON, 5'h03);
    mask(bsm_pkg::MSEL_LIN_OFF, 5'h03);
    chk("lin_q hold", 64'h4, lin_q);
    lreq(1'b1, 1'b0, 5'h03, 1'b1);
    chk("lin_q", 64'hC, lin_q);
    tick(1);
    chk("lin_on_evt_q", 64'h8, lin_on_evt_q);
    lreq(1'b0, 1'b1, 5'h03, 1'b0);
    chk("lin_q", 64'h4, lin_q);
    tick(1);
    chk("lin_off_evt_q", 64'h8, lin_off_evt_q);
    lreq(1'b1, 1'b1, 5'h06, 1'b1);
    chk("lin_q", 64'h44, lin_q);
    // Remote link alone sets and then clears a hold-mode bit
    tick(1);
    lreq(1'b0, 1'b1, 5'h07, 1'b1);
    chk("lin_q remote", 64'hC4, lin_q);
    tick(1);
    lreq(1'b0, 1'b1, 5'h07, 1'b0);
    chk("lin_q remote", 64'h44, lin_q);
    lin_mode_idx = 5'h04;
    lin_mode_pulse = 1'b1;
    lin_mode_we = 1'b1;
    tick(1);
    lin_mode_we = 1'b0;
    lreq(1'b1, 1'b0, 5'h04, 1'b1);
    chk("lin_q pulse", 64'h54, lin_q);
    tick(1);
    chk("lin_q pulse", 64'h44, lin_q);
    // Routing: digital input, logical output, trip and object status to relays and LEDs
    route(5'h00, 7'h42, 1'b0);
    route(5'h01, 7'h25, 1'b0);
    route(5'h09, 7'h50, 1'b0);
    route(5'h08, 7'h43, 1'b1);
    route(5'h0A, 7'h60, 1'b0);
    mask(bsm_pkg::MSEL_LOUT_ON, 5'h05);
    mask(bsm_pkg::MSEL_LOUT_OFF, 5'h05);
    ind_cfg_idx = 3'h0;
    ind_cfg_src = 7'h42;
    ind_cfg_we = 1'b1;
    tick(1);
    ind_cfg_we = 1'b0;
    din = 8'h0C;
    logic_result = 32'h20;
    stage_trip = 8'h01;
    obj_status = 8'h01;
    tick(2);
    chk("lout_on_evt_q", 64'h20, lout_on_evt_q);
    chk("ind_on_q", 64'h1, ind_on_q);
    tick(28);
    chk("relay_q", 64'h3, relay_q);
    chk("led_q", 64'h7, led_q);
    din = 8'h00;
    logic_result = 32'h0;
    stage_trip = 8'h00;
    obj_status = 8'h00;
    tick(2);
    chk("lout_off_evt_q", 64'h20, lout_off_evt_q);
    chk("ind_on_q", 64'h0, ind_on_q);
    tick(28);
    chk("relay_q", 64'h0, relay_q);
    chk("led_q latched", 64'h1, led_q);
    tap(1'b0);
    chk("led_q no view", 64'h1, led_q);
    latch_clear = 1'b1;
    tick(1);
    latch_clear = 1'b0;
    tick(30);
    chk("led_q cleared", 64'h0, led_q);
    din = 8'h08;
    tick(30);
    din = 8'h00;
    tick(30);
    tap(1'b1);
    chk("led_q back key", 64'h0, led_q);
    pcs_cfg_idx = 3'h1;
    pcs_cfg_level = 2'h2;
    pcs_cfg_we = 1'b1;
    tick(1);
    pcs_cfg_we = 1'b0;
    preq(3'h1, 1'b1, 2'h1);
    chk("pcs denied", {63'h0, 1'b1}, {63'h0, pcs_denied_q});
    tick(1);
    preq(3'h1, 1'b1, 2'h2);
    chk("pcs switch", 64'h2, panel_control_switch_q);
    // Mid-run reset must wipe banks, latches and switches again
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    tick(1);
    chk("outputs after reset", 64'h0, {lin_q, relay_q, led_q, panel_control_switch_q});
    close_out();
  end
endmodule : testbench

`default_nettype wire
